// >>> verilog/line_cycle_energy.sv
// Summary of operation
// - Mode register bit 0 enables line-cycle accumulation
// - Count reached: accumulators move to result registers
// - Half-cycle count is 16-bit unsigned crossings
// - Crossings counted only from selected phases
// - Crossing counter runs always; first result partial
// - Count write in line mode restarts counter
// - Done sets status bit 5, masked interrupt low
// - Writing one clears done flag, interrupt high
// - Both modes share one active energy path
// - Instantaneous reactive power stored per phase
// - Filter select resets zero, one filters total paths harder
// - Reactive gain: one plus value over 2^23
// - 0xc00000 halves, 0x400000 adds half
// - Separate gains for total and fundamental paths
// - Gains read as zero-padded, sign extended words
// - Per-phase signed offsets for both reactive paths
// - Fundamental reactive settles within 375/875 ms
// - Read-clear outside line mode zeroes energy reads
module line_cycle_energy #(
    parameter int SAMPLE_DIV = lc_energy_pkg::SAMPLE_DIV_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire lc_energy_pkg::reg_req_t reg_req,
    output logic [lc_energy_pkg::DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    input wire lc_energy_pkg::phase_samples_t [lc_energy_pkg::NUM_PHASES-1:0] samples,
    input wire logic [lc_energy_pkg::NUM_PHASES-1:0] zero_cross,
    output logic sample_tick,
    output logic first_interrupt_out_n
);
    import lc_energy_pkg::*;

    localparam int DIV_W = $clog2(SAMPLE_DIV);
    localparam int HITS_W = $clog2(NUM_PHASES + 1);

    // Divider needs at least two cycles per sample
    if (SAMPLE_DIV < 2)
    begin : g_bad_div
        $error("line_cycle_energy: SAMPLE_DIV must be at least 2");
    end

    // Sample rate divider
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_d;
    logic tick_q; // One-cycle power sample enable
    logic tick_d;

    // Software-visible control
    logic [MODE_W-1:0] mode_q; // Line-cycle mode register
    logic [MODE_W-1:0] mode_d;
    logic [COUNT_W-1:0] half_q; // Half-cycle count
    logic [COUNT_W-1:0] half_d;
    logic done_q; // Line-cycle done flag
    logic done_d;
    logic mask_q; // Done interrupt enable
    logic mask_d;
    logic filt_sel_q; // Power filter select
    logic filt_sel_d;
    logic irq_n_q;
    logic irq_n_d;
    logic [GAIN_W-1:0] tgain_q [NUM_PHASES];
    logic [GAIN_W-1:0] tgain_d [NUM_PHASES];
    logic [GAIN_W-1:0] fgain_q [NUM_PHASES];
    logic [GAIN_W-1:0] fgain_d [NUM_PHASES];
    logic [GAIN_W-1:0] tofs_q [NUM_PHASES];
    logic [GAIN_W-1:0] tofs_d [NUM_PHASES];
    logic [GAIN_W-1:0] fofs_q [NUM_PHASES];
    logic [GAIN_W-1:0] fofs_d [NUM_PHASES];

    // Energy state
    logic [ENERGY_W-1:0] tres_q [NUM_PHASES]; // Total active result
    logic [ENERGY_W-1:0] tres_d [NUM_PHASES];
    logic [ENERGY_W-1:0] fres_q [NUM_PHASES]; // Fundamental active result
    logic [ENERGY_W-1:0] fres_d [NUM_PHASES];
    logic [ENERGY_W-1:0] tacc_q [NUM_PHASES]; // Hidden line-cycle accumulators
    logic [ENERGY_W-1:0] tacc_d [NUM_PHASES];
    logic [ENERGY_W-1:0] facc_q [NUM_PHASES];
    logic [ENERGY_W-1:0] facc_d [NUM_PHASES];
    logic [COUNT_W-1:0] zx_cnt_q; // Zero-crossing counter
    logic [COUNT_W-1:0] zx_cnt_d;

    // Read port
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic rvalid_q;

    // Datapath outputs
    logic signed [POWER_W-1:0] ta_filt [NUM_PHASES]; // Filtered total active
    logic signed [POWER_W-1:0] tvar [NUM_PHASES]; // Instantaneous total reactive
    logic signed [POWER_W-1:0] fvar [NUM_PHASES]; // Instantaneous fundamental reactive

    // Decode helpers
    logic line_en;
    logic read_clear;
    logic [NUM_PHASES-1:0] zx_sel;
    logic [HITS_W-1:0] hits;
    logic [COUNT_W:0] cnt_sum;
    logic reached;
    logic half_write;
    logic done_clear;
    logic [ENERGY_W-1:0] ta_ext;
    logic [ENERGY_W-1:0] fa_ext;

    // Per-phase filter, gain and offset stages
    for (genvar p = 0; p < NUM_PHASES; p++)
    begin : g_phase
        // Total active filtered here too, no gain stage in this block
        power_scale u_total_active (
            .clk(clk),
            .arst_n(arst_n),
            .sample_en(tick_q),
            .strong_filter(filt_sel_q),
            .power_in(samples[p].total_active),
            .gain('0),
            .offset('0),
            .power_out(ta_filt[p])
        );
        // Total reactive uses its own gain and offset
        power_scale u_total_var (
            .clk(clk),
            .arst_n(arst_n),
            .sample_en(tick_q),
            .strong_filter(filt_sel_q),
            .power_in(samples[p].total_reactive),
            .gain(tgain_q[p]),
            .offset(tofs_q[p]),
            .power_out(tvar[p])
        );
        // Fundamental path keeps light filtering to meet its settling time
        power_scale u_fund_var (
            .clk(clk),
            .arst_n(arst_n),
            .sample_en(tick_q),
            .strong_filter(1'b0),
            .power_in(samples[p].fund_reactive),
            .gain(fgain_q[p]),
            .offset(fofs_q[p]),
            .power_out(fvar[p])
        );
    end

    // Sample divider
    always_comb
    begin
        tick_d = (div_q == DIV_W'(SAMPLE_DIV - 1));
        div_d = tick_d ? '0 : div_q + 1'b1;
    end

    // Zero-crossing counting and mode decode
    always_comb
    begin
        line_en = mode_q[LC_ACTIVE_EN_BIT];
        read_clear = mode_q[LC_READ_CLEAR_BIT] && !line_en;
        zx_sel = mode_q[LC_ZX_SEL_MSB:LC_ZX_SEL_LSB] & zero_cross;
        hits = '0;
        for (int p = 0; p < NUM_PHASES; p++)
        begin
            hits = hits + HITS_W'(zx_sel[p]);
        end
        cnt_sum = {1'b0, zx_cnt_q} + (COUNT_W+1)'(hits);
        reached = (half_q != '0) && (cnt_sum >= {1'b0, half_q});
        half_write = reg_req.wr && (reg_req.addr == REG_HALF_CYCLE);
        // Counter keeps running whether or not the mode is on
        zx_cnt_d = reached ? '0 : cnt_sum[COUNT_W-1:0];
        if (half_write && line_en)
        begin
            zx_cnt_d = '0;
        end
    end

    // Register writes and energy accumulation
    always_comb
    begin
        mode_d = mode_q;
        half_d = half_q;
        mask_d = mask_q;
        filt_sel_d = filt_sel_q;
        done_clear = 1'b0;
        ta_ext = '0;
        fa_ext = '0;
        tgain_d = tgain_q;
        fgain_d = fgain_q;
        tofs_d = tofs_q;
        fofs_d = fofs_q;
        tres_d = tres_q;
        fres_d = fres_q;
        tacc_d = tacc_q;
        facc_d = facc_q;
        if (reg_req.wr)
        begin
            case (reg_req.addr)
                REG_LINE_MODE: mode_d = reg_req.wdata[MODE_W-1:0];
                REG_HALF_CYCLE: half_d = reg_req.wdata[COUNT_W-1:0];
                REG_STATUS: done_clear = reg_req.wdata[DONE_FLAG_BIT];
                REG_MASK: mask_d = reg_req.wdata[DONE_FLAG_BIT];
                REG_CONFIG: filt_sel_d = reg_req.wdata[FILTER_SEL_BIT];
                default: mode_d = mode_q;
            endcase
            // Upper port bits are ignored on write; only the low 24 are kept
            for (int p = 0; p < NUM_PHASES; p++)
            begin
                if (reg_req.addr == REG_TGAIN_BASE + ADDR_W'(p))
                begin
                    tgain_d[p] = reg_req.wdata[GAIN_W-1:0];
                end
                if (reg_req.addr == REG_FGAIN_BASE + ADDR_W'(p))
                begin
                    fgain_d[p] = reg_req.wdata[GAIN_W-1:0];
                end
                if (reg_req.addr == REG_TOFS_BASE + ADDR_W'(p))
                begin
                    tofs_d[p] = reg_req.wdata[GAIN_W-1:0];
                end
                if (reg_req.addr == REG_FOFS_BASE + ADDR_W'(p))
                begin
                    fofs_d[p] = reg_req.wdata[GAIN_W-1:0];
                end
            end
        end
        for (int p = 0; p < NUM_PHASES; p++)
        begin
            // Same samples feed both modes, so one LSB means the same energy
            ta_ext = {{(ENERGY_W - POWER_W){ta_filt[p][POWER_W-1]}}, ta_filt[p]};
            fa_ext = {{(ENERGY_W - POWER_W){samples[p].fund_active[POWER_W-1]}},
                samples[p].fund_active};
            if (line_en)
            begin
                if (tick_q)
                begin
                    tacc_d[p] = tacc_q[p] + ta_ext;
                    facc_d[p] = facc_q[p] + fa_ext;
                end
                if (reached)
                begin
                    tres_d[p] = tacc_d[p];
                    fres_d[p] = facc_d[p];
                    tacc_d[p] = '0;
                    facc_d[p] = '0;
                end
                if (half_write)
                begin
                    tacc_d[p] = '0;
                    facc_d[p] = '0;
                end
            end
            else
            begin
                // Hidden accumulators idle at zero outside line mode
                tacc_d[p] = '0;
                facc_d[p] = '0;
                if (read_clear && reg_req.rd && reg_req.addr == REG_TENERGY_BASE + ADDR_W'(p))
                begin
                    tres_d[p] = '0;
                end
                if (read_clear && reg_req.rd && reg_req.addr == REG_FENERGY_BASE + ADDR_W'(p))
                begin
                    fres_d[p] = '0;
                end
                // A sample landing on the clearing read is kept, not lost
                if (tick_q)
                begin
                    tres_d[p] = tres_d[p] + ta_ext;
                    fres_d[p] = fres_d[p] + fa_ext;
                end
            end
        end
        // Set wins over a clear in the same cycle
        done_d = (line_en && reached) ? 1'b1 : (done_clear ? 1'b0 : done_q);
        irq_n_d = !(done_d && mask_d);
    end

    // Register read mux
    always_comb
    begin
        rdata_d = '0;
        case (reg_req.addr)
            REG_LINE_MODE: rdata_d = DATA_W'(mode_q);
            REG_HALF_CYCLE: rdata_d = DATA_W'(half_q);
            REG_STATUS: rdata_d = DATA_W'(done_q) << DONE_FLAG_BIT;
            REG_MASK: rdata_d = DATA_W'(mask_q) << DONE_FLAG_BIT;
            REG_CONFIG: rdata_d = DATA_W'(filt_sel_q) << FILTER_SEL_BIT;
            default: rdata_d = '0; // Unmapped reads as zero
        endcase
        for (int p = 0; p < NUM_PHASES; p++)
        begin
            if (reg_req.addr == REG_TGAIN_BASE + ADDR_W'(p))
            begin
                rdata_d = present_24(tgain_q[p]);
            end
            if (reg_req.addr == REG_FGAIN_BASE + ADDR_W'(p))
            begin
                rdata_d = present_24(fgain_q[p]);
            end
            if (reg_req.addr == REG_TOFS_BASE + ADDR_W'(p))
            begin
                rdata_d = present_24(tofs_q[p]);
            end
            if (reg_req.addr == REG_FOFS_BASE + ADDR_W'(p))
            begin
                rdata_d = present_24(fofs_q[p]);
            end
            if (reg_req.addr == REG_TENERGY_BASE + ADDR_W'(p))
            begin
                rdata_d = tres_q[p];
            end
            if (reg_req.addr == REG_FENERGY_BASE + ADDR_W'(p))
            begin
                rdata_d = fres_q[p];
            end
            if (reg_req.addr == REG_TVAR_BASE + ADDR_W'(p))
            begin
                rdata_d = present_28(tvar[p]);
            end
            if (reg_req.addr == REG_FVAR_BASE + ADDR_W'(p))
            begin
                rdata_d = present_28(fvar[p]);
            end
        end
        if (!reg_req.rd)
        begin
            rdata_d = rdata_q; // Hold last read data
        end
    end

    // All block state
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            div_q <= '0;
            tick_q <= 1'b0;
            mode_q <= LINE_MODE_RESET;
            half_q <= HALF_CYCLE_RESET;
            done_q <= 1'b0;
            mask_q <= 1'b0;
            filt_sel_q <= 1'b0;
            irq_n_q <= 1'b1;
            zx_cnt_q <= '0;
            rdata_q <= '0;
            rvalid_q <= 1'b0;
            for (int p = 0; p < NUM_PHASES; p++)
            begin
                tgain_q[p] <= GAIN_RESET;
                fgain_q[p] <= GAIN_RESET;
                tofs_q[p] <= GAIN_RESET;
                fofs_q[p] <= GAIN_RESET;
                tres_q[p] <= ENERGY_RESET;
                fres_q[p] <= ENERGY_RESET;
                tacc_q[p] <= ENERGY_RESET;
                facc_q[p] <= ENERGY_RESET;
            end
        end
        else
        begin
            div_q <= div_d;
            tick_q <= tick_d;
            mode_q <= mode_d;
            half_q <= half_d;
            done_q <= done_d;
            mask_q <= mask_d;
            filt_sel_q <= filt_sel_d;
            irq_n_q <= irq_n_d;
            zx_cnt_q <= zx_cnt_d;
            rdata_q <= rdata_d;
            rvalid_q <= reg_req.rd;
            tgain_q <= tgain_d;
            fgain_q <= fgain_d;
            tofs_q <= tofs_d;
            fofs_q <= fofs_d;
            tres_q <= tres_d;
            fres_q <= fres_d;
            tacc_q <= tacc_d;
            facc_q <= facc_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign sample_tick = tick_q;
    assign first_interrupt_out_n = irq_n_q;

endmodule

// >>> verilog/lc_energy_pkg.sv
package lc_energy_pkg;

    // Clocking and sample rate
    localparam int CLK_FREQ_HZ = 40_000_000;
    localparam int SAMPLE_RATE_HZ = 8_000;
    localparam int SAMPLE_DIV_CYCLES = CLK_FREQ_HZ / SAMPLE_RATE_HZ;

    // Fundamental reactive settling, in milliseconds
    localparam int FUND_SETTLE_63PCT_MS = 375;
    localparam int FUND_SETTLE_FULL_MS = 875;
    localparam int FUND_SETTLE_FULL_SAMPLES = FUND_SETTLE_FULL_MS * (SAMPLE_RATE_HZ / 1000);

    // Full-scale in-phase power word
    localparam int FULL_SCALE_POWER_CONST = 33_516_139;
    localparam int VAR_SCALE_SHIFT = 4;

    // Widths
    localparam int NUM_PHASES = 3;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int POWER_W = 28;
    localparam int GAIN_W = 24;
    localparam int ENERGY_W = 32;
    localparam int COUNT_W = 16;
    localparam int MODE_W = 7;
    localparam int GAIN_FRAC_BITS = 23;
    localparam int PAD_W = DATA_W - POWER_W;

    // Power filter strengths (shift of the one-pole step)
    localparam int FILT_SHIFT_LIGHT = 2;
    localparam int FILT_SHIFT_STRONG = 4;

    // Field positions
    localparam int LC_ACTIVE_EN_BIT = 0;
    localparam int LC_ZX_SEL_LSB = 3;
    localparam int LC_ZX_SEL_MSB = 5;
    localparam int LC_READ_CLEAR_BIT = 6;
    localparam int DONE_FLAG_BIT = 5;
    localparam int FILTER_SEL_BIT = 0;

    // Register indices
    localparam logic [ADDR_W-1:0] REG_LINE_MODE = 8'h00;
    localparam logic [ADDR_W-1:0] REG_HALF_CYCLE = 8'h01;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h02;
    localparam logic [ADDR_W-1:0] REG_MASK = 8'h03;
    localparam logic [ADDR_W-1:0] REG_CONFIG = 8'h04;
    localparam logic [ADDR_W-1:0] REG_TGAIN_BASE = 8'h05;
    localparam logic [ADDR_W-1:0] REG_FGAIN_BASE = 8'h08;
    localparam logic [ADDR_W-1:0] REG_TOFS_BASE = 8'h0b;
    localparam logic [ADDR_W-1:0] REG_FOFS_BASE = 8'h0e;
    localparam logic [ADDR_W-1:0] REG_TENERGY_BASE = 8'h11;
    localparam logic [ADDR_W-1:0] REG_FENERGY_BASE = 8'h14;
    localparam logic [ADDR_W-1:0] REG_TVAR_BASE = 8'h17;
    localparam logic [ADDR_W-1:0] REG_FVAR_BASE = 8'h1a;

    // Reset values
    localparam logic [MODE_W-1:0] LINE_MODE_RESET = 7'h00;
    localparam logic [COUNT_W-1:0] HALF_CYCLE_RESET = 16'hffff;
    localparam logic [GAIN_W-1:0] GAIN_RESET = 24'h000000;
    localparam logic [ENERGY_W-1:0] ENERGY_RESET = 32'h00000000;

    // Register access request from the serial port engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

    // Per-phase power samples from the front-end datapath
    typedef struct packed {
        logic signed [POWER_W-1:0] total_active;
        logic signed [POWER_W-1:0] fund_active;
        logic signed [POWER_W-1:0] total_reactive;
        logic signed [POWER_W-1:0] fund_reactive;
    } phase_samples_t;

    // 24-bit signed word as seen on the port: top nibble zero, sign to 28 bits
    function automatic logic [DATA_W-1:0] present_24(input logic [GAIN_W-1:0] v);
        present_24 = {{PAD_W{1'b0}}, {(POWER_W - GAIN_W){v[GAIN_W-1]}}, v};
    endfunction

    // 28-bit signed power word sign extended to the port width
    function automatic logic [DATA_W-1:0] present_28(input logic [POWER_W-1:0] v);
        present_28 = {{PAD_W{v[POWER_W-1]}}, v};
    endfunction

endpackage

// >>> verilog/power_scale.sv
module power_scale #(
    parameter int PW = lc_energy_pkg::POWER_W,
    parameter int GW = lc_energy_pkg::GAIN_W
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic sample_en,
    input wire logic strong_filter,
    input wire logic signed [PW-1:0] power_in,
    input wire logic signed [GW-1:0] gain,
    input wire logic signed [GW-1:0] offset,
    output logic signed [PW-1:0] power_out
);
    import lc_energy_pkg::*;

    // Extra fraction bits keep the filter from stalling on small steps
    localparam int EXT = PW + FILT_SHIFT_STRONG;

    // Refuse shapes the arithmetic cannot serve
    if (GW > PW || GW <= GAIN_FRAC_BITS)
    begin : g_bad_width
        $error("power_scale: gain width must exceed fraction bits and not exceed power width");
    end

    logic signed [EXT-1:0] filt_q; // Filter state, extended precision
    logic signed [EXT-1:0] filt_d;
    logic signed [PW-1:0] out_q; // Scaled result
    logic signed [PW-1:0] out_d;
    logic signed [EXT:0] diff; // Input minus state
    logic signed [EXT:0] step;
    logic signed [PW-1:0] filt; // Filter output at sample width
    logic signed [PW+GW-1:0] prod;
    logic signed [PW+GW-1:0] prod_sh;
    logic signed [PW+1:0] sum;

    // One-pole low-pass, then gain and offset
    always_comb
    begin
        diff = (EXT+1)'($signed({power_in, {FILT_SHIFT_STRONG{1'b0}}})) - (EXT+1)'(filt_q);
        // Stronger setting trades settling time for ripple
        if (strong_filter)
        begin
            step = diff >>> FILT_SHIFT_STRONG;
        end
        else
        begin
            step = diff >>> FILT_SHIFT_LIGHT;
        end
        filt = filt_q[EXT-1:FILT_SHIFT_STRONG];
        // Result times (1 + gain / 2^23)
        prod = filt * gain;
        prod_sh = prod >>> GAIN_FRAC_BITS;
        // Offset added after gain; wraps rather than saturates at extremes
        sum = (PW+2)'(filt) + (PW+2)'($signed(prod_sh[PW:0])) + (PW+2)'(offset);
        filt_d = filt_q;
        out_d = out_q;
        if (sample_en)
        begin
            filt_d = filt_q + step[EXT-1:0];
            out_d = sum[PW-1:0];
        end
    end

    // State registers
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            filt_q <= '0;
            out_q <= '0;
        end
        else
        begin
            filt_q <= filt_d;
            out_q <= out_d;
        end
    end

    assign power_out = out_q;

endmodule

// >>> tb/lc_energy_asserts.sv
module lc_energy_asserts
    import lc_energy_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire reg_req_t reg_req,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic [NUM_PHASES-1:0] zero_cross,
    input wire logic first_interrupt_out_n
);
    // One clock domain, one reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // Status read, shorthand
    wire logic st_rd = reg_req.rd && reg_req.addr == REG_STATUS;
    // Write of one to the done position
    wire logic st_clr = reg_req.wr && reg_req.addr == REG_STATUS && reg_req.wdata[DONE_FLAG_BIT];
    // Mask write, which may raise or release a pending interrupt
    wire logic mk_wr = reg_req.wr && reg_req.addr == REG_MASK;

    property p_rd_answer; reg_req.rd |=> reg_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read left unanswered");
    property p_no_stray; !reg_req.rd |=> !reg_rvalid; endproperty
    a_no_stray: assert property (p_no_stray) else $error("valid without read");
    property p_gain_fmt;
        reg_req.rd && reg_req.addr inside {[8'h05:8'h10]} |=>
            reg_rdata[31:28] == 4'h0 && reg_rdata[27:24] == {4{reg_rdata[23]}};
    endproperty
    a_gain_fmt: assert property (p_gain_fmt) else $error("gain word badly padded");
    property p_var_fmt;
        reg_req.rd && reg_req.addr inside {[8'h17:8'h1c]} |=> reg_rdata[31:28] == {4{reg_rdata[27]}};
    endproperty
    a_var_fmt: assert property (p_var_fmt) else $error("power word not sign extended");
    property p_irq_fall;
        $fell(first_interrupt_out_n) |-> $past(zero_cross) != 3'h0 || $past(mk_wr);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt without crossing");
    property p_irq_rise; $rose(first_interrupt_out_n) |-> $past(st_clr) || $past(mk_wr); endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("interrupt released unasked");
    property p_clear; st_clr && zero_cross == 3'h0 |=> first_interrupt_out_n; endproperty
    a_clear: assert property (p_clear) else $error("interrupt not released");
    property p_irq_flag; st_rd && !first_interrupt_out_n |=> reg_rdata[DONE_FLAG_BIT]; endproperty
    a_irq_flag: assert property (p_irq_flag) else $error("interrupt low, flag clear");
    property p_st_bits; st_rd |=> reg_rdata[31:6] == 26'h0 && reg_rdata[4:0] == 5'h00; endproperty
    a_st_bits: assert property (p_st_bits) else $error("stray status bits");
endmodule

bind line_cycle_energy lc_energy_asserts i_asserts (.clk(clk), .arst_n(arst_n),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .zero_cross(zero_cross), .first_interrupt_out_n(first_interrupt_out_n));

// >>> tb/line_cycle_energy_bench.sv
module line_cycle_energy_bench
    import lc_energy_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Short sample divider keeps runs brief
    localparam int DIV = 16;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    reg_req_t req = '0;
    phase_samples_t [NUM_PHASES-1:0] smp = '0;
    logic [NUM_PHASES-1:0] zc = 3'h0;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic tick;
    logic irq_n;
    logic [2:0] sel = 3'h0; // Mirror of the crossing select field
    logic zc_on = 1'b0;
    int fails = 0;
    int num_checks = 0;
    int ticks = 0; // Ticks seen at sampling edges
    int hits = 0; // Selected crossings seen
    int k = 0;
    logic [DATA_W-1:0] v; // Last read word

    line_cycle_energy #(.SAMPLE_DIV(DIV)) i_dut (.clk(clk), .arst_n(arst_n), .reg_req(req),
        .reg_rdata(rdata), .reg_rvalid(rvalid), .samples(smp), .zero_cross(zc),
        .sample_tick(tick), .first_interrupt_out_n(irq_n));

    // 40 MHz clock
    initial forever #12.5 clk = ~clk;

    // Counters and crossing pulses; long spacing lets reads finish inside an interval
    always @(posedge clk)
    begin
        ticks <= ticks + int'(tick === 1'b1);
        hits <= hits + $countones(zc & sel);
        k <= k + 1;
        zc <= (zc_on && k % 31 == 0) ? 3'h7 : 3'h0;
    end

    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One register cycle; reads land in v at the following negedge
    task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        req <= {w, !w, a, d};
        @(posedge clk);
        req <= '0;
        if (!w)
        begin
            @(negedge clk);
            v = rdata;
        end
    endtask

    // Expected port view of a 24-bit signed word
    function automatic logic [DATA_W-1:0] fmt24(input logic [DATA_W-1:0] d);
        fmt24 = {4'h0, {4{d[23]}}, d[23:0]};
    endfunction

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog, well beyond the expected run
    initial
    begin
        #(25 * 30000);
        fails++;
        conclude();
    end

    initial
    begin
        logic [DATA_W-1:0] d;
        int half, n, t0, h0, t1, h1;
        int f [NUM_PHASES];
        v = $urandom(32'h40bbb42e);
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        chk(irq_n, 1'b1);
        acc(0, REG_LINE_MODE, 0);
        chk(v, 32'h0);
        acc(0, REG_HALF_CYCLE, 0);
        chk(v, 32'h0000ffff);
        acc(0, REG_CONFIG, 0);
        chk(v, 32'h0);
        // Gains and offsets: reset, random, and the half-scale codes
        for (int i = 5; i < 17; i++)
        begin
            acc(0, i[7:0], 0);
            chk(v, 32'h0);
            d = (i == 5) ? 32'h00c00000 : (i == 8) ? 32'h00400000 : $urandom;
            acc(1, i[7:0], d);
            acc(0, i[7:0], 0);
            chk(v, fmt24(d));
        end
        // Settled phase A reactive: total gain halves, fundamental adds half, plus offsets
        acc(1, REG_TOFS_BASE, 32'h10);
        acc(1, REG_FOFS_BASE, 32'hfffffff0);
        smp[0].total_reactive <= 28'h1000;
        smp[0].fund_reactive <= 28'h1000;
        repeat (60 * DIV) @(posedge clk);
        acc(0, REG_TVAR_BASE, 0);
        chk(v >= 2063 && v <= 2064, 1);
        acc(0, REG_FVAR_BASE, 0);
        chk(v >= 6126 && v <= 6128, 1);
        acc(1, REG_CONFIG, 1);
        acc(0, REG_CONFIG, 0);
        chk(v, 32'h1);
        acc(1, 8'h40, 32'hffffffff);
        acc(0, 8'h40, 0);
        chk(v, 32'h0);
        for (int i = 23; i < 29; i++)
            acc(0, i[7:0], 0);
        acc(1, REG_MASK, 32'h20);
        // Every nonzero crossing select combination, two back-to-back intervals each
        for (int s = 1; s < 8; s++)
        begin
            for (int p = 0; p < NUM_PHASES; p++)
            begin
                f[p] = $urandom_range(1000);
                smp[p].fund_active <= 28'(f[p]);
                smp[p].total_active <= 28'($urandom);
                smp[p].total_reactive <= 28'($urandom);
                smp[p].fund_reactive <= 28'($urandom);
            end
            acc(1, REG_LINE_MODE, {26'h0, s[2:0], 3'h1});
            sel = s[2:0];
            acc(1, REG_STATUS, 32'h20);
            half = $urandom_range(8, 2);
            // Keep a sample tick off the restarting edge
            do @(posedge clk); while (tick !== 1'b1);
            acc(1, REG_HALF_CYCLE, half);
            @(negedge clk);
            t0 = ticks;
            h0 = hits;
            zc_on = 1'b1;
            for (int r = 0; r < 2; r++)
            begin
                n = 0;
                while (irq_n !== 1'b0 && n < 2000)
                begin
                    @(negedge clk);
                    n++;
                end
                t1 = ticks;
                h1 = hits;
                chk(h1 - h0 >= half && h1 - h0 - $countones(s) < half, 1);
                for (int p = 0; p < NUM_PHASES; p++)
                begin
                    acc(0, REG_FENERGY_BASE + 8'(p), 0);
                    chk(v, (t1 - t0) * f[p]);
                end
                acc(0, REG_STATUS, 0);
                chk(v, 32'h20);
                acc(1, REG_STATUS, 32'h20);
                acc(0, REG_STATUS, 0);
                chk(v, 32'h0);
                chk(irq_n, 1'b1);
                t0 = t1;
                h0 = h1;
            end
            zc_on = 1'b0;
        end
        // Read-clear outside line mode: a second read right after sees zero
        smp[0].fund_active <= 28'h10;
        acc(1, REG_LINE_MODE, 32'h40);
        do @(posedge clk); while (tick !== 1'b1);
        acc(0, REG_FENERGY_BASE, 0);
        chk(v != 0, 1);
        acc(0, REG_FENERGY_BASE, 0);
        chk(v, 32'h0);
        conclude();
    end
endmodule
